// file: bit_test_defines.svh
// opcode, flag position and cycle count constants for the bit test datapath
`ifndef BIT_TEST_DEFINES_SVH
`define BIT_TEST_DEFINES_SVH

// opcode high nibbles of the two-operand groups and of the swap group
`define OPHI_CTEST    4'h6
`define OPHI_ZTEST    4'h7
`define OPHI_XOR      4'hB
`define OPHI_SWAP     4'hF
// lowest and highest low nibble of a two-operand group
`define OPLO_FIRST    4'h2
`define OPLO_SHORT    4'h2
`define OPLO_LAST     4'h6
// lowest and highest low nibble of the swap group
`define OPLO_SWAP_R   4'h0
`define OPLO_SWAP_IR  4'h1
// whole opcodes
`define OPC_HALT      8'h3F
`define OPC_ZTEST_IM  8'h76
`define OPC_SWAP_IR   8'hF1

// flag positions in the six-bit flag vector; FLG_W at 6 lies outside it
`define FLG_C         5
`define FLG_Z         4
`define FLG_S         3
`define FLG_V         2
`define FLG_D         1
`define FLG_H         0
`define FLG_W         6

// cycle counts per instruction form
`define CYC_SHORT     3'h4
`define CYC_LONG      3'h6
`define CYC_ILLEGAL   3'h1
`define CYC_WAIT_UNIT 3'h4

`endif

// file: bit_test_pkg.sv
// types shared by the bit test datapath modules
package bit_test_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_WAIT
    } seq_state_t;

    // decoded operation class
    typedef enum logic [2:0] {
        OC_NONE,
        OC_ZTEST,
        OC_CTEST,
        OC_XOR,
        OC_SWAP,
        OC_HALT
    } op_class_t;

endpackage : bit_test_pkg

// file: op_eval.sv
// combinational evaluation of result and zero/sign for one operation class
`timescale 1ns/1ps
`include "bit_test_defines.svh"

module op_eval (
    // decoded operation and operands
    input  wire bit_test_pkg::op_class_t op_class,
    input  wire logic [7:0]              dst,
    input  wire logic [7:0]              src,
    // evaluation result
    output logic [7:0]                   result,
    output logic                         writes_dst,
    output logic                         zero,
    output logic                         sign
);

    // one result path per class; tests only feed the flags
    always_comb begin
        result     = 8'h00;
        writes_dst = 1'b0;
        case (op_class)
            // RL1: mask selects bits checked for zero
            bit_test_pkg::OC_ZTEST: begin
                result = dst & src;
            end
            // RL5: inverted destination under mask
            bit_test_pkg::OC_CTEST: begin
                result = ~dst & src;
            end
            // RL12: xor written back to destination
            bit_test_pkg::OC_XOR: begin
                result     = dst ^ src;
                writes_dst = 1'b1;
            end
            // RL11: halves of the byte exchanged
            bit_test_pkg::OC_SWAP: begin
                result     = {dst[3:0], dst[7:4]};
                writes_dst = 1'b1;
            end
            default: begin
                result     = 8'h00;
                writes_dst = 1'b0;
            end
        endcase
        zero = (result == 8'h00);
        sign = result[7];
    end

endmodule : op_eval

// file: bit_test_logic_ops.sv
// sequencer for swap, masked bit tests, xor and the halt-until-interrupt wait
//
// Summary of operation
// RL1: zero test ANDs destination with mask
// RL2: zero flag set when selected bits zero
// RL3: zero test writes flags only
// RL4: immediate zero test opcode 76, six cycles
// RL5: complement test sets zero when selected ones
// RL6: wait halts execution, transfers continue
// RL7: internal interrupt ends the wait
// RL8: wait opcode 3F lasts multiples of four
// RL9: xor zero and sign from result
// RL10: xor clears overflow, keeps carry, D, H
// RL11: swap exchanges nibbles, indirect opcode F1
// RL12: xor writes result, source untouched
`timescale 1ns/1ps
`include "bit_test_defines.svh"

module bit_test_logic_ops (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // decoded instruction from the decoder
    input  wire logic       exec_start,
    input  wire logic [7:0] exec_opcode,
    input  wire logic [7:0] dst_data,
    input  wire logic [7:0] src_data,
    input  wire logic [5:0] flags_in,
    // interrupt request from the interrupt structure
    input  wire logic       irq_req,
    // sequencing status
    output logic            busy_r,
    output logic            done_r,
    output logic            illegal_r,
    output logic            cpu_halt_r,
    // write-back to register file and flags
    output logic            dst_we_r,
    output logic [7:0]      dst_wdata_r,
    output logic            flags_we_r,
    output logic [5:0]      flags_out_r
);

    // opcode to operation class, shared by the sequencer and the checks
    function automatic bit_test_pkg::op_class_t decode_class(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        logic       grp;
        hi  = op[7:4];
        lo  = op[3:0];
        grp = (lo >= `OPLO_FIRST) && (lo <= `OPLO_LAST);
        if (op == `OPC_HALT) begin
            decode_class = bit_test_pkg::OC_HALT;
        end else if (hi == `OPHI_ZTEST && grp) begin
            decode_class = bit_test_pkg::OC_ZTEST;
        end else if (hi == `OPHI_CTEST && grp) begin
            decode_class = bit_test_pkg::OC_CTEST;
        end else if (hi == `OPHI_XOR && grp) begin
            decode_class = bit_test_pkg::OC_XOR;
        end else if (hi == `OPHI_SWAP && (lo == `OPLO_SWAP_R || lo == `OPLO_SWAP_IR)) begin
            decode_class = bit_test_pkg::OC_SWAP;
        end else begin
            decode_class = bit_test_pkg::OC_NONE;
        end
    endfunction : decode_class

    // cycle count of one instruction; register-register forms are short
    function automatic logic [2:0] cycles_of(input logic [7:0] op);
        bit_test_pkg::op_class_t cls;
        cls = decode_class(op);
        if (cls == bit_test_pkg::OC_NONE) begin
            cycles_of = `CYC_ILLEGAL;
        end else if (cls == bit_test_pkg::OC_HALT) begin
            cycles_of = `CYC_WAIT_UNIT;
        end else if (cls == bit_test_pkg::OC_SWAP || op[3:0] == `OPLO_SHORT) begin
            cycles_of = `CYC_SHORT;
        end else begin
            cycles_of = `CYC_LONG;
        end
    endfunction : cycles_of

    bit_test_pkg::seq_state_t state_r;
    bit_test_pkg::seq_state_t state_nxt;
    bit_test_pkg::op_class_t  class_r;
    bit_test_pkg::op_class_t  class_nxt;
    bit_test_pkg::op_class_t  dec_class;
    logic [2:0]               cnt_r;
    logic [2:0]               cnt_nxt;
    logic [7:0]               res_r;
    logic [7:0]               res_nxt;
    logic                     wdst_r;
    logic                     wdst_nxt;
    logic [5:0]               flg_r;
    logic [5:0]               flg_nxt;
    logic                     irq_seen_r;
    logic                     irq_seen_nxt;
    logic                     busy_nxt;
    logic                     done_nxt;
    logic                     illegal_nxt;
    logic                     halt_nxt;
    logic                     dst_we_nxt;
    logic [7:0]               dst_wdata_nxt;
    logic                     flags_we_nxt;
    logic [5:0]               flags_out_nxt;
    logic [7:0]               ev_result;
    logic                     ev_writes;
    logic                     ev_zero;
    logic                     ev_sign;
    logic                     start_ok;

    assign dec_class = decode_class(exec_opcode);
    assign start_ok  = exec_start && (state_r == bit_test_pkg::ST_IDLE);

    // operands are evaluated once at acceptance, held until completion
    op_eval op_eval_i (
        .op_class   (dec_class),
        .dst        (dst_data),
        .src        (src_data),
        .result     (ev_result),
        .writes_dst (ev_writes),
        .zero       (ev_zero),
        .sign       (ev_sign)
    );

    // next-state logic of the sequencer and its write-back outputs
    always_comb begin
        state_nxt     = state_r;
        class_nxt     = class_r;
        cnt_nxt       = cnt_r;
        res_nxt       = res_r;
        wdst_nxt      = wdst_r;
        flg_nxt       = flg_r;
        irq_seen_nxt  = irq_seen_r;
        done_nxt      = 1'b0;
        illegal_nxt   = 1'b0;
        dst_we_nxt    = 1'b0;
        dst_wdata_nxt = dst_wdata_r;
        flags_we_nxt  = 1'b0;
        flags_out_nxt = flags_out_r;
        halt_nxt      = cpu_halt_r;
        case (state_r)
            bit_test_pkg::ST_IDLE: begin
                if (start_ok) begin
                    class_nxt = dec_class;
                    cnt_nxt   = cycles_of(exec_opcode) - 3'h1;
                    res_nxt   = ev_result;
                    // RL3: tests never write the destination
                    wdst_nxt  = ev_writes;
                    // carry, decimal-adjust and half-carry pass through
                    flg_nxt   = flags_in;
                    // RL2: zero flag carries the test outcome
                    flg_nxt[`FLG_Z] = ev_zero;
                    // RL9: sign follows result bit 7
                    flg_nxt[`FLG_S] = ev_sign;
                    // RL10: overflow cleared; swap leaves it undefined, kept
                    if (dec_class != bit_test_pkg::OC_SWAP) begin
                        flg_nxt[`FLG_V] = 1'b0;
                    end
                    if (dec_class == bit_test_pkg::OC_HALT) begin
                        // RL6: only instruction execution is gated
                        state_nxt    = bit_test_pkg::ST_WAIT;
                        halt_nxt     = 1'b1;
                        irq_seen_nxt = irq_req;
                    end else begin
                        state_nxt = bit_test_pkg::ST_EXEC;
                    end
                end
            end
            bit_test_pkg::ST_EXEC: begin
                if (cnt_r == 3'h0) begin
                    // RL4: completion after the form's cycle count
                    state_nxt     = bit_test_pkg::ST_IDLE;
                    done_nxt      = 1'b1;
                    illegal_nxt   = (class_r == bit_test_pkg::OC_NONE);
                    dst_we_nxt    = wdst_r;
                    dst_wdata_nxt = res_r;
                    flags_we_nxt  = (class_r != bit_test_pkg::OC_NONE);
                    flags_out_nxt = flg_r;
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            bit_test_pkg::ST_WAIT: begin
                // request is held so one seen mid-unit is not missed
                irq_seen_nxt = irq_seen_r || irq_req;
                if (cnt_r == 3'h0) begin
                    // RL7: any internal interrupt, fast included, ends the wait
                    if (irq_seen_r || irq_req) begin
                        state_nxt    = bit_test_pkg::ST_IDLE;
                        done_nxt     = 1'b1;
                        halt_nxt     = 1'b0;
                        irq_seen_nxt = 1'b0;
                    end else begin
                        // RL8: wait extends by whole units of four
                        cnt_nxt = `CYC_WAIT_UNIT - 3'h1;
                    end
                end else begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            default: begin
                state_nxt = bit_test_pkg::ST_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != bit_test_pkg::ST_IDLE);
    end

    // registers of the sequencer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r     <= bit_test_pkg::ST_IDLE;
            class_r     <= bit_test_pkg::OC_NONE;
            cnt_r       <= 3'h0;
            res_r       <= 8'h00;
            wdst_r      <= 1'b0;
            flg_r       <= 6'h00;
            irq_seen_r  <= 1'b0;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            illegal_r   <= 1'b0;
            cpu_halt_r  <= 1'b0;
            dst_we_r    <= 1'b0;
            dst_wdata_r <= 8'h00;
            flags_we_r  <= 1'b0;
            flags_out_r <= 6'h00;
        end else begin
            state_r     <= state_nxt;
            class_r     <= class_nxt;
            cnt_r       <= cnt_nxt;
            res_r       <= res_nxt;
            wdst_r      <= wdst_nxt;
            flg_r       <= flg_nxt;
            irq_seen_r  <= irq_seen_nxt;
            busy_r      <= busy_nxt;
            done_r      <= done_nxt;
            illegal_r   <= illegal_nxt;
            cpu_halt_r  <= halt_nxt;
            dst_we_r    <= dst_we_nxt;
            dst_wdata_r <= dst_wdata_nxt;
            flags_we_r  <= flags_we_nxt;
            flags_out_r <= flags_out_nxt;
        end
    end

    // helper state read only by the checks below
    logic [7:0] dq_r;
    logic [7:0] sq_r;
    logic [5:0] fq_r;
    logic [7:0] halt_len_r;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dq_r       <= 8'h00;
            sq_r       <= 8'h00;
            fq_r       <= 6'h00;
            halt_len_r <= 8'h00;
        end else begin
            if (start_ok) begin
                dq_r <= dst_data;
                sq_r <= src_data;
                fq_r <= flags_in;
            end
            halt_len_r <= cpu_halt_r ? halt_len_r + 8'h01 : 8'h00;
        end
    end

    property p_zt_no_write;
        @(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_ZTEST |-> !dst_we_r && flags_we_r;
    endproperty
    a_zt_no_write: assert property (p_zt_no_write) else $error("zero test wrote dst"); // RL3

    property p_zt_zero;
        @(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_ZTEST
            |-> flags_out_r[`FLG_Z] == ((dq_r & sq_r) == 8'h00);
    endproperty
    a_zt_zero: assert property (p_zt_zero) else $error("zero test Z wrong"); // RL1 RL2

    property p_ct_zero;
        @(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_CTEST
            |-> flags_out_r[`FLG_Z] == ((dq_r & sq_r) == sq_r) && !dst_we_r;
    endproperty
    a_ct_zero: assert property (p_ct_zero) else $error("complement test Z wrong"); // RL5

    property p_zt_imm_len;
        @(posedge ref_clk) disable iff (srst)
        start_ok && exec_opcode == `OPC_ZTEST_IM |=> !done_r[*6] ##1 done_r;
    endproperty
    a_zt_imm_len: assert property (p_zt_imm_len) else $error("imm zero test not 6 cycles"); // RL4

    property p_halt_enter;
        @(posedge ref_clk) disable iff (srst)
        start_ok && exec_opcode == `OPC_HALT |=> cpu_halt_r[*4];
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt not held a unit"); // RL6

    property p_halt_units;
        @(posedge ref_clk) disable iff (srst)
        $fell(cpu_halt_r) |-> halt_len_r[1:0] == 2'h0 && halt_len_r != 8'h00 && done_r;
    endproperty
    a_halt_units: assert property (p_halt_units) else $error("wait not multiple of 4"); // RL8

    property p_halt_wake;
        @(posedge ref_clk) disable iff (srst)
        cpu_halt_r && irq_req |-> ##[1:4] !cpu_halt_r;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("interrupt did not end wait"); // RL7

    property p_xor_flags;
        @(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_XOR
            |-> !flags_out_r[`FLG_V] && flags_out_r[`FLG_S] == (dq_r[7] ^ sq_r[7])
                && flags_out_r[`FLG_Z] == (dq_r == sq_r)
                && flags_out_r[`FLG_C] == fq_r[`FLG_C] && flags_out_r[`FLG_D] == fq_r[`FLG_D]
                && flags_out_r[`FLG_H] == fq_r[`FLG_H];
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong"); // RL9 RL10

    property p_xor_write;
        @(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_XOR |-> dst_we_r && dst_wdata_r == (dq_r ^ sq_r);
    endproperty
    a_xor_write: assert property (p_xor_write) else $error("xor result wrong"); // RL12

    property p_swap;
        @(posedge ref_clk) disable iff (srst)
        start_ok && exec_opcode == `OPC_SWAP_IR
            |=> ##4 done_r && dst_we_r && dst_wdata_r == {dq_r[3:0], dq_r[7:4]};
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong"); // RL11

    c_ztest: cover property (@(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_ZTEST && flags_out_r[`FLG_Z]);
    c_ctest: cover property (@(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_CTEST);
    c_long_wait: cover property (@(posedge ref_clk) disable iff (srst)
        $fell(cpu_halt_r) && halt_len_r == 8'h08);
    c_xor: cover property (@(posedge ref_clk) disable iff (srst)
        done_r && class_r == bit_test_pkg::OC_XOR);

endmodule : bit_test_logic_ops

// file: bit_test_logic_ops_tb_top.sv
// self-checking bench for the bit test, xor, swap and wait datapath
`timescale 1ns/1ps

module bit_test_logic_ops_tb_top;
    // stimulus towards the block
    logic       ref_clk;
    logic       srst;
    logic       exec_start;
    logic [7:0] exec_opcode;
    logic [7:0] dst_data;
    logic [7:0] src_data;
    logic [5:0] flags_in;
    logic       irq_req;
    // observed outputs
    logic       busy_r;
    logic       done_r;
    logic       illegal_r;
    logic       cpu_halt_r;
    logic       dst_we_r;
    logic [7:0] dst_wdata_r;
    logic       flags_we_r;
    logic [5:0] flags_out_r;
    // bookkeeping
    int         err_count;
    int         n_compared;

    bit_test_logic_ops bit_test_logic_ops_i (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .exec_start  (exec_start),
        .exec_opcode (exec_opcode),
        .dst_data    (dst_data),
        .src_data    (src_data),
        .flags_in    (flags_in),
        .irq_req     (irq_req),
        .busy_r      (busy_r),
        .done_r      (done_r),
        .illegal_r   (illegal_r),
        .cpu_halt_r  (cpu_halt_r),
        .dst_we_r    (dst_we_r),
        .dst_wdata_r (dst_wdata_r),
        .flags_we_r  (flags_we_r),
        .flags_out_r (flags_out_r)
    );

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // comparison helpers, one per result kind
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_flags(input logic [5:0] got, input logic [5:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: flags got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flags

    task automatic cmp_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("unexpected at %0t: cycles got %0d exp %0d", $time, got, exp);
        end
    endtask : cmp_count

    // expected flags: c kept, z and s from result, v cleared unless kept, d h kept
    function automatic logic [5:0] fexp(input logic [7:0] r, input logic [5:0] f,
                                        input logic keep_v);
        return {f[5], r == 8'h00, r[7], keep_v ? f[2] : 1'b0, f[1:0]};
    endfunction : fexp

    // one instruction; irq_at 0 raises the interrupt with the request, j>0 at edge j
    task automatic run_op(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
                          input logic [5:0] f, input int irq_at, input int cyc,
                          input logic we, input logic [7:0] wd, input logic fw,
                          input logic [5:0] ef, input logic ill, input logic halt);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge ref_clk);
        exec_start  <= 1'b1;
        exec_opcode <= op;
        dst_data    <= d;
        src_data    <= s;
        flags_in    <= f;
        irq_req     <= (irq_at == 0);
        @(posedge ref_clk);
        exec_start <= 1'b0;
        // bounded wait for completion, checking busy and halt meanwhile
        while (!seen && n < 40) begin
            @(posedge ref_clk);
            if (irq_at > 0 && n + 1 == irq_at) irq_req <= 1'b1;
            #1;
            n++;
            seen = (done_r === 1'b1);
            if (!seen) begin
                cmp_bit(busy_r, 1'b1, "busy");
                cmp_bit(cpu_halt_r, halt, "halt");
            end
        end
        cmp_count(n, cyc);
        cmp_bit(busy_r, 1'b0, "busy at done");
        cmp_bit(cpu_halt_r, 1'b0, "halt at done");
        cmp_bit(illegal_r, ill, "illegal");
        cmp_bit(dst_we_r, we, "dst write");
        cmp_bit(flags_we_r, fw, "flags write");
        if (we) cmp_byte(dst_wdata_r, wd, "result");
        if (fw) cmp_flags(flags_out_r, ef);
        // completion strobe is a single cycle
        @(posedge ref_clk);
        #1;
        cmp_bit(done_r, 1'b0, "done width");
    endtask : run_op

    // zero test over every form; mask bits pick destination bits tested for 0
    task automatic zero_test_forms();
        for (int i = 0; i < 5; i++) begin
            run_op(8'(8'h72 + i), 8'h2B, 8'h54, 6'h2F, -1, (i == 0) ? 4 : 6,
                   1'b0, 8'h00, 1'b1, fexp(8'h00, 6'h2F, 1'b0), 1'b0, 1'b0);
            run_op(8'(8'h72 + i), 8'hC7, 8'h82, 6'h10, -1, (i == 0) ? 4 : 6,
                   1'b0, 8'h00, 1'b1, fexp(8'h82, 6'h10, 1'b0), 1'b0, 1'b0);
        end
    endtask : zero_test_forms

    // complement test over every form, including an empty mask
    task automatic complement_test_forms();
        for (int i = 0; i < 5; i++) begin
            run_op(8'(8'h62 + i), 8'hC7, 8'h02, 6'h04, -1, (i == 0) ? 4 : 6,
                   1'b0, 8'h00, 1'b1, fexp(8'h00, 6'h04, 1'b0), 1'b0, 1'b0);
            run_op(8'(8'h62 + i), 8'h2B, 8'h94, 6'h23, -1, (i == 0) ? 4 : 6,
                   1'b0, 8'h00, 1'b1, fexp(8'h94, 6'h23, 1'b0), 1'b0, 1'b0);
        end
        run_op(8'h62, 8'h00, 8'h00, 6'h00, -1, 4, 1'b0, 8'h00, 1'b1,
               fexp(8'h00, 6'h00, 1'b0), 1'b0, 1'b0);
    endtask : complement_test_forms

    // xor over every form, overflow preset so its clearing shows
    task automatic xor_forms();
        for (int i = 0; i < 5; i++) begin
            run_op(8'(8'hB2 + i), 8'hC7, 8'h02, 6'h3F, -1, (i == 0) ? 4 : 6,
                   1'b1, 8'hC5, 1'b1, fexp(8'hC5, 6'h3F, 1'b0), 1'b0, 1'b0);
            run_op(8'(8'hB2 + i), 8'h5A, 8'h5A, 6'h04, -1, (i == 0) ? 4 : 6,
                   1'b1, 8'h00, 1'b1, fexp(8'h00, 6'h04, 1'b0), 1'b0, 1'b0);
        end
    endtask : xor_forms

    // nibble swap, direct and register-indirect
    task automatic swap_forms();
        run_op(8'hF0, 8'h3E, 8'h11, 6'h24, -1, 4, 1'b1, 8'hE3, 1'b1,
               fexp(8'hE3, 6'h24, 1'b1), 1'b0, 1'b0);
        run_op(8'hF1, 8'hA4, 8'h00, 6'h1B, -1, 4, 1'b1, 8'h4A, 1'b1,
               fexp(8'h4A, 6'h1B, 1'b1), 1'b0, 1'b0);
        run_op(8'hF1, 8'h00, 8'hFF, 6'h00, -1, 4, 1'b1, 8'h00, 1'b1,
               fexp(8'h00, 6'h00, 1'b1), 1'b0, 1'b0);
    endtask : swap_forms

    // opcodes outside this block finish at once with nothing written
    task automatic illegal_opcodes();
        run_op(8'h3E, 8'h12, 8'h34, 6'h00, -1, 1, 1'b0, 8'h00, 1'b0, 6'h00, 1'b1, 1'b0);
        run_op(8'h77, 8'h12, 8'h34, 6'h00, -1, 1, 1'b0, 8'h00, 1'b0, 6'h00, 1'b1, 1'b0);
    endtask : illegal_opcodes

    // wait exits only on whole four-cycle blocks after the interrupt
    task automatic halt_wait();
        run_op(8'h3F, 8'h00, 8'h00, 6'h00, 0, 4, 1'b0, 8'h00, 1'b0, 6'h00, 1'b0, 1'b1);
        run_op(8'h3F, 8'h00, 8'h00, 6'h00, 6, 8, 1'b0, 8'h00, 1'b0, 6'h00, 1'b0, 1'b1);
        run_op(8'h3F, 8'h00, 8'h00, 6'h00, 9, 12, 1'b0, 8'h00, 1'b0, 6'h00, 1'b0, 1'b1);
    endtask : halt_wait

    // request held through busy is ignored; next one taken at the edge after the done edge
    task automatic back_to_back();
        @(posedge ref_clk);
        exec_start  <= 1'b1;
        exec_opcode <= 8'hB2;
        dst_data    <= 8'hC7;
        src_data    <= 8'h02;
        flags_in    <= 6'h00;
        irq_req     <= 1'b0;
        @(posedge ref_clk);
        exec_opcode <= 8'h4F;
        dst_data    <= 8'hFF;
        repeat (3) @(posedge ref_clk);
        exec_opcode <= 8'hF0;
        dst_data    <= 8'h3E;
        flags_in    <= 6'h04;
        @(posedge ref_clk);
        #1;
        cmp_bit(done_r, 1'b1, "first done");
        cmp_byte(dst_wdata_r, 8'hC5, "first result");
        cmp_bit(illegal_r, 1'b0, "ignored request");
        // sequencer is idle only from the done cycle, so the swap is taken here
        @(posedge ref_clk);
        exec_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        cmp_bit(done_r, 1'b0, "second early");
        @(posedge ref_clk);
        #1;
        cmp_bit(done_r, 1'b1, "second done");
        cmp_byte(dst_wdata_r, 8'hE3, "second result");
        cmp_flags(flags_out_r, fexp(8'hE3, 6'h04, 1'b1));
    endtask : back_to_back

    // verdict and end of run
    task automatic results();
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        results();
    end

    // main sequence
    initial begin
        err_count   = 0;
        n_compared  = 0;
        srst        = 1'b1;
        exec_start  = 1'b0;
        exec_opcode = 8'h00;
        dst_data    = 8'h00;
        src_data    = 8'h00;
        flags_in    = 6'h00;
        irq_req     = 1'b0;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        cmp_bit(busy_r | done_r | illegal_r | cpu_halt_r, 1'b0, "status after reset");
        cmp_bit(dst_we_r | flags_we_r, 1'b0, "writes after reset");
        zero_test_forms();
        complement_test_forms();
        xor_forms();
        swap_forms();
        illegal_opcodes();
        back_to_back();
        halt_wait();
        results();
    end

endmodule : bit_test_logic_ops_tb_top
